//--- lbc_pkg.sv
// How it works
// - Local loop sends transmit data to receive.
// - Remote loop sends recovered data to transmit.
// - Remote loop ignores transmit data inputs.
// - Auto loop enters after 5 s loop-up.
// - Entering auto loop sets active flag.
// - Auto loop leaves after 5 s loop-down.
// - Clearing auto enable resets auto logic.
// - Effective remote loop is manual OR auto.
// - Analog loop feeds transmit line to receiver.
// - Analog loop ignores incoming line signals.
// - Bypass skips attenuator for recovered path.
// - Low three bits select error source.
package lbc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses on the bus.
	localparam logic [7:0] LBC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] LBC_ISR_ADDR  = 8'h04;
	localparam logic [7:0] LBC_IMR_ADDR  = 8'h08;
	localparam logic [7:0] LBC_STAT_ADDR = 8'h0C;

	// Values after reset.
	localparam logic [7:0] LBC_CTRL_RST  = 8'h00;
	localparam logic [1:0] LBC_IRQ_RST   = 2'h0;

	// Interrupt status bit positions.
	localparam int LBC_EV_ENTER = 0;
	localparam int LBC_EV_LEAVE = 1;

	// Pattern qualification time and the clock rate.
	localparam longint LBC_QUAL_TIME_S = 5;
	localparam longint LBC_CLK_HZ      = 40000000;
	localparam int LBC_QUAL_CYCLES =
		int'(LBC_QUAL_TIME_S * LBC_CLK_HZ);
	localparam int LBC_QUAL_W = 28;

	////////////////////////////////////////////////////////////////////////
	// Control register layout, most significant bit first.
	typedef struct packed {
		logic       local_loop_enable;
		logic       remote_loop_enable;
		logic       auto_remote_loop_enable;
		logic       analog_loop_enable;
		logic       recovered_path_ja_bypass;
		logic [2:0] err_count_select;
	} lbc_ctrl_t;

	// One bipolar data pair.
	typedef struct packed {
		logic pos;
		logic neg;
	} lbc_pair_t;

	// Automatic loop states, Gray coded along off, armed, looped.
	typedef enum logic [1:0] {
		LBC_OFF    = 2'b00,
		LBC_ARMED  = 2'b01,
		LBC_LOOPED = 2'b11
	} lbc_state_t;

endpackage

//--- lbc_qual.sv
`timescale 1ns/1ps
module lbc_qual import lbc_pkg::*; #(
	parameter int CYCLES = LBC_QUAL_CYCLES,
	parameter int W      = LBC_QUAL_W
) (
	// Clock and reset.
	input  wire logic mclk_in,
	input  wire logic rst_in,
	// Qualification control.
	input  wire logic clear_in,
	input  wire logic detect_in,
	// One-cycle pulse once the pattern has held long enough.
	output logic      done_out
);

	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;  // Consecutive detect cycles seen.

	////////////////////////////////////////////////////////////////////////
	// Count detect cycles; any gap restarts the count from zero.
	always_ff @(posedge mclk_in) begin
		if (rst_in || clear_in || !detect_in) begin
			cnt_q <= '0;
		end else if (cnt_q != LAST) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	// Fire once when the last counted cycle still sees the pattern.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			done_out <= 1'b0;
		end else begin
			done_out <= !clear_in && detect_in && cnt_q == LAST - W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	restart_count_a: assert property (
		!detect_in |=> cnt_q == '0)
		else $error("qualifier did not restart on a gap");
	done_only_full_a: assert property (
		done_out |-> $past(cnt_q) == LAST - W'(1) && $past(detect_in))
		else $error("qualifier fired before the full interval");

endmodule

//--- lbc_core.sv
`timescale 1ns/1ps
module lbc_core import lbc_pkg::*; #(
	parameter int QUAL_CYCLES = LBC_QUAL_CYCLES
) (
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// AHB-Lite slave port.
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Transmit data from the framer.
	input  wire lbc_pair_t   tx_data_in,
	// Recovered data and clock from clock/data recovery.
	input  wire lbc_pair_t   cdr_data_in,
	input  wire logic        cdr_clk_in,
	// Jitter attenuator return path.
	input  wire lbc_pair_t   ja_data_in,
	input  wire logic        ja_clk_in,
	// Receive line inputs.
	input  wire logic        line_rx_tip_in,
	input  wire logic        line_rx_ring_in,
	// Pattern detector levels.
	input  wire logic        loop_up_detect_in,
	input  wire logic        loop_down_detect_in,
	// Line side outputs.
	output logic             line_tx_tip_out,
	output logic             line_tx_ring_out,
	output lbc_pair_t        slicer_data_out,
	// Jitter attenuator feed.
	output lbc_pair_t        ja_feed_out,
	// Receive side toward the framer.
	output lbc_pair_t        rx_data_out,
	output logic             rx_clk_out,
	output logic             backplane_clock_out,
	// Status and selection.
	output logic [2:0]       err_sel_out,
	output logic             auto_loop_active_flag_out,
	output logic             irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode helpers.

	// True for a register address that exists.
	function automatic logic is_mapped(input logic [7:0] a);
		return a == LBC_CTRL_ADDR || a == LBC_ISR_ADDR ||
			a == LBC_IMR_ADDR || a == LBC_STAT_ADDR;
	endfunction

	lbc_ctrl_t   ctl_q;      // Control register.
	logic [1:0]  isr_q;      // Sticky event bits.
	logic [1:0]  imr_q;      // Interrupt mask, one enables.
	lbc_state_t  st_q;       // Automatic loop state.
	lbc_state_t  st_d;       // Next automatic loop state.
	logic        up_done;    // Loop-up held for the full time.
	logic        dn_done;    // Loop-down held for the full time.
	logic        rlb_eff;    // Effective remote loop.
	lbc_pair_t   rx_src;     // Receive source before attenuation.
	logic        wr_pend_q;  // Write data phase is due.
	logic [7:0]  wr_addr_q;  // Address of that write.
	logic        acc;        // Address phase taken this cycle.
	logic        wr_ctl;     // Control register written now.
	logic        wr_isr;     // Status register written now.
	logic [1:0]  ev;         // Events raised this cycle.
	logic [1:0]  isr_d;      // Next status bits.

	// Read value for an address, zero where nothing is mapped.
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		case (a)
			LBC_CTRL_ADDR: return {24'h000000, ctl_q};
			LBC_ISR_ADDR:  return {30'h0, isr_q};
			LBC_IMR_ADDR:  return {30'h0, imr_q};
			LBC_STAT_ADDR: return {31'h0, st_q == LBC_LOOPED};
			default:       return 32'h00000000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY.

	assign acc    = hsel_in && htrans_in[1] && hready_in;
	assign wr_ctl = wr_pend_q && wr_addr_q == LBC_CTRL_ADDR;
	assign wr_isr = wr_pend_q && wr_addr_q == LBC_ISR_ADDR;

	// Remember a write address phase for its data phase.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc && hwrite_in && is_mapped(haddr_in[7:0]);
			wr_addr_q <= haddr_in[7:0];
		end
	end

	// Read data is taken at the address phase and stands one cycle.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			hrdata_out <= 32'h00000000;
		end else if (acc && !hwrite_in) begin
			hrdata_out <= reg_read(haddr_in[7:0]);
		end else begin
			hrdata_out <= 32'h00000000;
		end
	end

	// The slave never stalls and never errors.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers.

	// Control register, written whole from the low byte.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ctl_q <= LBC_CTRL_RST;
		end else if (wr_ctl) begin
			ctl_q <= lbc_ctrl_t'(hwdata_in[7:0]);
		end
	end

	// Interrupt mask register.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			imr_q <= LBC_IRQ_RST;
		end else if (wr_pend_q && wr_addr_q == LBC_IMR_ADDR) begin
			imr_q <= hwdata_in[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Automatic remote loop.

	// Loop-up is timed only while armed, loop-down only while looped.
	lbc_qual #(
		.CYCLES (QUAL_CYCLES),
		.W      (LBC_QUAL_W)
	) u_up_qual (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.clear_in  (st_q != LBC_ARMED),
		.detect_in (loop_up_detect_in),
		.done_out  (up_done)
	);

	lbc_qual #(
		.CYCLES (QUAL_CYCLES),
		.W      (LBC_QUAL_W)
	) u_dn_qual (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.clear_in  (st_q != LBC_LOOPED),
		.detect_in (loop_down_detect_in),
		.done_out  (dn_done)
	);

	// Next state; a cleared enable drops everything back to off.
	always_comb begin
		st_d = st_q;
		if (!ctl_q.auto_remote_loop_enable) begin
			st_d = LBC_OFF;
		end else begin
			case (st_q)
				LBC_OFF: begin
					st_d = LBC_ARMED;
				end
				LBC_ARMED: begin
					if (up_done) begin
						st_d = LBC_LOOPED;
					end
				end
				LBC_LOOPED: begin
					if (dn_done) begin
						st_d = LBC_ARMED;
					end
				end
				default: begin
					st_d = LBC_OFF;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st_q <= LBC_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	// The active flag follows the looped state in the same cycle.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			auto_loop_active_flag_out <= 1'b0;
		end else begin
			auto_loop_active_flag_out <= st_d == LBC_LOOPED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Events and interrupt.

	// Entry and exit of the automatic loop are the two events.
	always_comb begin
		ev = 2'h0;
		ev[LBC_EV_ENTER] = st_q != LBC_LOOPED && st_d == LBC_LOOPED;
		ev[LBC_EV_LEAVE] = st_q == LBC_LOOPED && st_d != LBC_LOOPED;
		isr_d = isr_q;
		if (wr_isr) begin
			isr_d = isr_q & ~hwdata_in[1:0];
		end
		// A new event wins over a clear in the same cycle.
		isr_d = isr_d | ev;
	end

	// Sticky status bits.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			isr_q <= LBC_IRQ_RST;
		end else begin
			isr_q <= isr_d;
		end
	end

	// Level interrupt while any unmasked bit is set.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(isr_d & imr_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data paths.

	// Either the manual bit or the automatic logic loops remotely.
	assign rlb_eff = ctl_q.remote_loop_enable || st_q == LBC_LOOPED;

	// Receive source is transmit data during local loop.
	assign rx_src = ctl_q.local_loop_enable ? tx_data_in : cdr_data_in;

	// Attenuator feed carries the active loop path.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ja_feed_out <= '0;
		end else if (rlb_eff) begin
			ja_feed_out <= cdr_data_in;
		end else begin
			ja_feed_out <= rx_src;
		end
	end

	// Line transmit: framer data, or looped data that ignores it.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			line_tx_tip_out  <= 1'b0;
			line_tx_ring_out <= 1'b0;
		end else if (rlb_eff) begin
			line_tx_tip_out  <= ja_data_in.pos;
			line_tx_ring_out <= ja_data_in.neg;
		end else begin
			line_tx_tip_out  <= tx_data_in.pos;
			line_tx_ring_out <= tx_data_in.neg;
		end
	end

	// Slicer input: line, or our own transmit outputs in analog loop.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			slicer_data_out <= '0;
		end else if (ctl_q.analog_loop_enable) begin
			slicer_data_out <= {line_tx_tip_out, line_tx_ring_out};
		end else begin
			slicer_data_out <= {line_rx_tip_in, line_rx_ring_in};
		end
	end

	// Recovered clock and data, attenuated unless bypassed; the data also skips the attenuator during remote loop.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rx_data_out <= '0;
			rx_clk_out  <= 1'b0;
		end else if (ctl_q.recovered_path_ja_bypass) begin
			rx_data_out <= rx_src;
			rx_clk_out  <= cdr_clk_in;
		end else begin
			rx_data_out <= rlb_eff ? rx_src : ja_data_in;
			rx_clk_out  <= ja_clk_in;
		end
	end

	// Backplane clock always comes from the attenuator.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			backplane_clock_out <= 1'b0;
		end else begin
			backplane_clock_out <= ja_clk_in;
		end
	end

	// Error source select.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			err_sel_out <= 3'h0;
		end else begin
			err_sel_out <= ctl_q.err_count_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	local_loop_a: assert property (
		ctl_q.local_loop_enable && !rlb_eff |=>
		ja_feed_out == $past(tx_data_in) &&
		line_tx_tip_out == $past(tx_data_in.pos))
		else $error("local loop path wrong");
	remote_loop_a: assert property (
		rlb_eff |=> ja_feed_out == $past(cdr_data_in))
		else $error("remote loop feed wrong");
	tx_ignored_a: assert property (
		rlb_eff |=> line_tx_tip_out == $past(ja_data_in.pos) &&
		line_tx_ring_out == $past(ja_data_in.neg))
		else $error("transmit inputs not ignored");
	auto_enter_a: assert property (
		st_q == LBC_ARMED && up_done && ctl_q.auto_remote_loop_enable
		|=> st_q == LBC_LOOPED && auto_loop_active_flag_out)
		else $error("auto loop did not enter");
	enter_event_a: assert property (
		$rose(auto_loop_active_flag_out) |-> isr_q[LBC_EV_ENTER])
		else $error("entry event not recorded");
	auto_leave_a: assert property (
		st_q == LBC_LOOPED && dn_done |=>
		st_q != LBC_LOOPED && !auto_loop_active_flag_out)
		else $error("auto loop did not leave");
	auto_reset_a: assert property (
		$fell(ctl_q.auto_remote_loop_enable) |=>
		st_q == LBC_OFF && !auto_loop_active_flag_out)
		else $error("auto logic not reset");
	or_loop_a: assert property (
		st_q == LBC_LOOPED && !ctl_q.remote_loop_enable |=>
		line_tx_tip_out == $past(ja_data_in.pos))
		else $error("auto loop did not act");
	analog_loop_a: assert property (
		ctl_q.analog_loop_enable |=>
		slicer_data_out == $past({line_tx_tip_out, line_tx_ring_out}))
		else $error("analog loop path wrong");
	bypass_a: assert property (
		ctl_q.recovered_path_ja_bypass |=>
		rx_clk_out == $past(cdr_clk_in) &&
		backplane_clock_out == $past(ja_clk_in))
		else $error("bypass path wrong");
	err_select_a: assert property (
		##1 err_sel_out == $past(ctl_q.err_count_select))
		else $error("error select wrong");

	enter_c: cover property (st_q == LBC_ARMED ##1 st_q == LBC_LOOPED);
	leave_c: cover property (st_q == LBC_LOOPED ##1 st_q == LBC_ARMED);
	irq_c:   cover property ($rose(irq_out));
	local_c: cover property (ctl_q.local_loop_enable && !rlb_eff);

endmodule

//--- lbc_far.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Stand-in for the attenuator and clock recovery, driven from a phase counter
// so that the bench can predict every value that it hands to the block.
module lbc_far import lbc_pkg::*; (
	// Clock and reset.
	input  wire logic mclk_in,
	input  wire logic rst_in,
	// Attenuator and recovery outputs.
	output lbc_pair_t ja_data_out,
	output logic      ja_clk_out,
	output logic      cdr_clk_out,
	// Phase of the pattern, read by the bench.
	output logic [3:0] cnt_out
);
	logic [3:0] cnt_q; // Free-running phase counter.

	// The phase advances every cycle and restarts on reset.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// The clocks run at half and quarter rate, the data changes slower.
	assign ja_clk_out  = cnt_q[0];
	assign cdr_clk_out = cnt_q[1];
	assign ja_data_out = lbc_pair_t'(cnt_q[3:2]);
	assign cnt_out     = cnt_q;
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top import lbc_pkg::*; ;
	logic mclk_in, rst_in, hsel, hwrite, hrdy, hresp, up_det, dn_det;
	logic [31:0] haddr, hwdata, hrdata_out;
	logic [1:0]  htrans;
	lbc_pair_t   tx_d, cdr_d, ja_d, prev_lt;
	logic        rx_tip, rx_ring, ja_clk, cdr_clk;
	logic [3:0]  far_cnt;
	logic [12:0] dp_now;
	logic        rd_v, dp_v, dp_v1, fv, rem_a;
	logic [7:0]  cr;
	logic [31:0] rq[$];
	logic [12:0] dq[$];
	logic [1:0]  fq[$];
	int          n_mismatch, tests_run;
	logic        ltt, ltr, rclk, bpc, flag, irq;
	lbc_pair_t   sl, jf, rxd;
	logic [2:0]  esel;

	////////////////////////////////////////////////////////////////////////
	// The block under test and the far side.
	lbc_core #(.QUAL_CYCLES(8)) u_lbc_core (.mclk_in(mclk_in),
		.rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata_out),
		.hreadyout_out(hrdy), .hresp_out(hresp), .tx_data_in(tx_d),
		.cdr_data_in(cdr_d), .cdr_clk_in(cdr_clk), .ja_data_in(ja_d),
		.ja_clk_in(ja_clk), .line_rx_tip_in(rx_tip),
		.line_rx_ring_in(rx_ring), .loop_up_detect_in(up_det),
		.loop_down_detect_in(dn_det), .line_tx_tip_out(ltt),
		.line_tx_ring_out(ltr), .slicer_data_out(sl), .ja_feed_out(jf),
		.rx_data_out(rxd), .rx_clk_out(rclk), .backplane_clock_out(bpc),
		.err_sel_out(esel), .auto_loop_active_flag_out(flag),
		.irq_out(irq));
	lbc_far u_lbc_far (.mclk_in(mclk_in), .rst_in(rst_in),
		.ja_data_out(ja_d), .ja_clk_out(ja_clk), .cdr_clk_out(cdr_clk),
		.cnt_out(far_cnt));
	assign dp_now = {ltt, ltr, sl, jf, rxd, rclk, bpc, esel};

	// The clock runs at 40 MHz.
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison, counting and the closing verdict.
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The watcher takes the oldest note whenever a result stands.
	always @(posedge mclk_in) begin
		if (rd_v && hrdy === 1'b1) begin
			cmp(hrdata_out, rq.pop_front());
			cmp({31'h0, hresp}, 32'h0);
		end
		if (dp_v1) begin
			cmp({19'h0, dp_now}, {19'h0, dq.pop_front()});
		end
		if (fv) begin
			cmp({30'h0, flag, irq}, {30'h0, fq.pop_front()});
		end
		dp_v1 <= dp_v;
	end

	////////////////////////////////////////////////////////////////////////
	// One single word transfer; the master waits for ready in each phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk_in); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_v <= ~w;
		do @(posedge mclk_in); while (hrdy !== 1'b1);
		rd_v <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// Flag and interrupt levels are looked at in the next cycle.
	task automatic chkf(input logic [1:0] e);
		fq.push_back(e);
		fv <= 1'b1;
		@(posedge mclk_in);
		fv <= 1'b0;
	endtask

	task automatic hold(input logic u, input logic d, input int n);
		up_det <= u;
		dn_det <= d;
		repeat (n) @(posedge mclk_in);
	endtask

	// One cycle of random line traffic, with its outcome noted.
	task automatic step(input logic p);
		lbc_pair_t t, c, jd, src, lt, jx, rx, sx;
		logic [1:0] r;
		logic [3:0] n;
		logic rem;
		t = lbc_pair_t'(2'($urandom));
		c = lbc_pair_t'(2'($urandom));
		r = 2'($urandom);
		n = far_cnt + 4'h1;
		jd = lbc_pair_t'(n[3:2]);
		rem = cr[6] | rem_a;
		src = cr[7] ? t : c;
		lt = rem ? jd : t;
		jx = rem ? c : src;
		rx = (cr[3] | rem) ? src : jd;
		sx = cr[4] ? prev_lt : lbc_pair_t'(r);
		tx_d <= t;
		cdr_d <= c;
		{rx_tip, rx_ring} <= r;
		if (p) dq.push_back({lt, sx, jx, rx, cr[3] ? n[1] : n[0], n[0], cr[2:0]});
		dp_v <= p;
		prev_lt = lt;
		@(posedge mclk_in);
	endtask

	task automatic run(input int n);
		step(1'b0);
		repeat (n) step(1'b1);
		dp_v <= 1'b0;
	endtask

	// A hang is cut short well past the expected run length.
	initial begin
		repeat (20000) @(posedge mclk_in);
		n_mismatch++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [7:0] modes [9];
		logic [7:0] m;
		modes = '{8'h80, 8'h40, 8'hC0, 8'h10, 8'h50, 8'h08, 8'h48, 8'h98, 8'h07};
		{hsel, hwrite, up_det, dn_det, rx_tip, rx_ring} = 6'h00;
		{rd_v, dp_v, dp_v1, fv, rem_a} = 5'h00;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		tx_d = '0;
		cdr_d = '0;
		prev_lt = '0;
		cr = 8'h00;
		n_mismatch = 0;
		tests_run = 0;
		void'($urandom(78));
		rst_in = 1'b1;
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Reset values, including an unmapped place.
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
		$display("test reset done");
		// Every manual loop mode, the bypass and the select field.
		for (int i = 0; i < 10; i++) begin
			m = (i < 9) ? modes[i] : (8'($urandom) & 8'hDF);
			cr = m;
			bus(1'b1, LBC_CTRL_ADDR, {24'($urandom), m});
			rd(LBC_CTRL_ADDR, {24'h0, m});
			run(6);
		end
		$display("test modes done");
		// Automatic loop with an interrupted pattern first.
		bus(1'b1, LBC_IMR_ADDR, 32'h3);
		cr = 8'h20;
		bus(1'b1, LBC_CTRL_ADDR, 32'h20);
		hold(1'b1, 1'b0, 6);
		hold(1'b0, 1'b0, 1);
		hold(1'b1, 1'b0, 6);
		chkf(2'b00);
		hold(1'b1, 1'b0, 6);
		hold(1'b0, 1'b0, 2);
		chkf(2'b11);
		rd(LBC_STAT_ADDR, 32'h1);
		rd(LBC_ISR_ADDR, 32'h1);
		rem_a = 1'b1;
		run(6);
		hold(1'b0, 1'b1, 6);
		hold(1'b0, 1'b0, 1);
		hold(1'b0, 1'b1, 6);
		chkf(2'b11);
		hold(1'b0, 1'b1, 6);
		hold(1'b0, 1'b0, 2);
		chkf(2'b01);
		rem_a = 1'b0;
		run(4);
		rd(LBC_ISR_ADDR, 32'h3);
		bus(1'b1, LBC_ISR_ADDR, 32'h1);
		rd(LBC_ISR_ADDR, 32'h2);
		bus(1'b1, LBC_IMR_ADDR, 32'h0);
		hold(1'b0, 1'b0, 1);
		chkf(2'b00);
		bus(1'b1, LBC_ISR_ADDR, 32'h2);
		rd(LBC_ISR_ADDR, 32'h0);
		bus(1'b1, LBC_IMR_ADDR, 32'h3);
		$display("test auto loop done");
		// Clearing the enable while looped drops the loop at once.
		hold(1'b1, 1'b0, 12);
		hold(1'b0, 1'b0, 1);
		bus(1'b1, LBC_ISR_ADDR, 32'h3);
		chkf(2'b10);
		cr = 8'h00;
		bus(1'b1, LBC_CTRL_ADDR, 32'h0);
		hold(1'b0, 1'b0, 1);
		chkf(2'b01);
		rd(LBC_STAT_ADDR, 32'h0);
		cr = 8'h20;
		bus(1'b1, LBC_CTRL_ADDR, 32'h20);
		hold(1'b0, 1'b0, 2);
		chkf(2'b01);
		$display("test auto reset done");
		end_sim();
	end
endmodule
